/* File: pkg/gpio_map.vh */
`ifndef GPIO_MAP_VH
`define GPIO_MAP_VH

// Register kinds
`define GPIO_K_LVL  3'h0
`define GPIO_K_OUTV 3'h1
`define GPIO_K_DIR  3'h2
`define GPIO_K_FLG  3'h3
`define GPIO_K_POL  3'h4
`define GPIO_K_IEN  3'h5
`define GPIO_K_FSEL 3'h6
`define GPIO_K_PULL 3'h7

// Byte addresses, port 1
`define GPIO_P1_LVL  8'h20
`define GPIO_P1_OUTV 8'h21
`define GPIO_P1_DIR  8'h22
`define GPIO_P1_FLG  8'h23
`define GPIO_P1_POL  8'h24
`define GPIO_P1_IEN  8'h25
`define GPIO_P1_FSEL 8'h26
`define GPIO_P1_PULL 8'h27
// Port 2
`define GPIO_P2_LVL  8'h28
`define GPIO_P2_OUTV 8'h29
`define GPIO_P2_DIR  8'h2a
`define GPIO_P2_FLG  8'h2b
`define GPIO_P2_POL  8'h2c
`define GPIO_P2_IEN  8'h2d
`define GPIO_P2_FSEL 8'h2e
`define GPIO_P2_PULL 8'h2f
// Ports 3 to 6
`define GPIO_P3_LVL  8'h18
`define GPIO_P3_OUTV 8'h19
`define GPIO_P3_DIR  8'h1a
`define GPIO_P3_FSEL 8'h1b
`define GPIO_P3_PULL 8'h10
`define GPIO_P4_LVL  8'h1c
`define GPIO_P4_OUTV 8'h1d
`define GPIO_P4_DIR  8'h1e
`define GPIO_P4_FSEL 8'h1f
`define GPIO_P4_PULL 8'h11
`define GPIO_P5_LVL  8'h30
`define GPIO_P5_OUTV 8'h31
`define GPIO_P5_DIR  8'h32
`define GPIO_P5_FSEL 8'h33
`define GPIO_P5_PULL 8'h12
`define GPIO_P6_LVL  8'h34
`define GPIO_P6_OUTV 8'h35
`define GPIO_P6_DIR  8'h36
`define GPIO_P6_FSEL 8'h37
`define GPIO_P6_PULL 8'h13
// Ports 7/8 (low wide pair) and 9/10 (high wide pair)
`define GPIO_P7_LVL   8'h38
`define GPIO_P7_OUTV  8'h3a
`define GPIO_P7_DIR   8'h3c
`define GPIO_P7_FSEL  8'h3e
`define GPIO_P7_PULL  8'h14
`define GPIO_P8_LVL   8'h39
`define GPIO_P8_OUTV  8'h3b
`define GPIO_P8_DIR   8'h3d
`define GPIO_P8_FSEL  8'h3f
`define GPIO_P8_PULL  8'h15
`define GPIO_P9_LVL   8'h08
`define GPIO_P9_OUTV  8'h0a
`define GPIO_P9_DIR   8'h0c
`define GPIO_P9_FSEL  8'h0e
`define GPIO_P9_PULL  8'h16
`define GPIO_P10_LVL  8'h09
`define GPIO_P10_OUTV 8'h0b
`define GPIO_P10_DIR  8'h0d
`define GPIO_P10_FSEL 8'h0f
`define GPIO_P10_PULL 8'h17

// Reset values and edge-detect arm count
`define GPIO_RST_BYTE    8'h00
`define GPIO_RST_P2_FSEL 8'hc0
`define GPIO_ARM_CYCLES  2'h3

`endif

/* File: design/gpio_edge.v */
`timescale 1ns/100ps
`include "gpio_map.vh"

module gpio_edge (
    input  wire       clk_i,
    input  wire       reset_i,
    input  wire [7:0] pin_i,
    input  wire [7:0] polarity_i,
    input  wire [7:0] func_sel_i,
    input  wire [7:0] irq_en_i,
    input  wire       global_irq_enable_i,
    input  wire       flag_we_i,
    input  wire [7:0] flag_wdata_i,
    output wire [7:0] flags_o,
    output wire       irq_o
);
    reg  [7:0] sync1_r;
    reg  [7:0] sync2_r;
    reg  [7:0] trig_prev_r;
    reg  [7:0] flags_r;
    reg  [1:0] arm_r;
    wire [7:0] trig;
    wire [7:0] set_ev;
    wire [7:0] flags_nxt;

    // Polarity folded into the level, so a polarity change acts as an edge
    assign trig      = sync2_r ^ polarity_i;
    // Held off until the chain is filled, avoids a false set after reset
    assign set_ev    = trig & ~trig_prev_r & ~func_sel_i
                       & {8{arm_r == `GPIO_ARM_CYCLES}};
    // Hardware set wins over a same-cycle software clear
    assign flags_nxt = (flag_we_i ? flag_wdata_i : flags_r) | set_ev;

    always @(posedge clk_i) begin
        if (reset_i) begin
            sync1_r     <= `GPIO_RST_BYTE;
            sync2_r     <= `GPIO_RST_BYTE;
            trig_prev_r <= `GPIO_RST_BYTE;
            flags_r     <= `GPIO_RST_BYTE;
            arm_r       <= 2'h0;
        end else begin
            sync1_r     <= pin_i;
            sync2_r     <= sync1_r;
            trig_prev_r <= trig;
            flags_r     <= flags_nxt;
            if (arm_r != `GPIO_ARM_CYCLES) begin
                arm_r <= arm_r + 2'h1;
            end
        end
    end

    assign flags_o = flags_r;
    // Level request, stays up while global enable is set and any enabled flag is pending
    assign irq_o   = global_irq_enable_i
                     & (|(flags_r & irq_en_i));

endmodule // gpio_edge

/* File: design/gpio_ports.v */
`timescale 1ns/100ps
`include "gpio_map.vh"


module gpio_ports (
    input  wire        clk_i,
    input  wire        reset_i,
    input  wire [7:0]  addr_i,
    input  wire [15:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    input  wire        byte_i,
    output wire [15:0] rdata_o,
    input  wire        global_irq_enable_i,
    input  wire [79:0] pad_in_i,
    output wire [79:0] pad_out_o,
    output wire [79:0] pad_oe_n_o,
    output wire [79:0] pull_en_o,
    output wire [79:0] pull_up_o,
    input  wire [79:0] periph_out_i,
    output wire [79:0] periph_in_o,
    output wire        port1_irq_o,
    output wire        port2_irq_o
);
    // Decode: {hit, kind[2:0], port[3:0]}
    function [7:0] gpio_decode;
        input [7:0] a;
        begin
            case (a)
                `GPIO_P1_LVL:   gpio_decode = {1'b1, `GPIO_K_LVL,  4'h0};
                `GPIO_P1_OUTV:  gpio_decode = {1'b1, `GPIO_K_OUTV, 4'h0};
                `GPIO_P1_DIR:   gpio_decode = {1'b1, `GPIO_K_DIR,  4'h0};
                `GPIO_P1_FLG:   gpio_decode = {1'b1, `GPIO_K_FLG,  4'h0};
                `GPIO_P1_POL:   gpio_decode = {1'b1, `GPIO_K_POL,  4'h0};
                `GPIO_P1_IEN:   gpio_decode = {1'b1, `GPIO_K_IEN,  4'h0};
                `GPIO_P1_FSEL:  gpio_decode = {1'b1, `GPIO_K_FSEL, 4'h0};
                `GPIO_P1_PULL:  gpio_decode = {1'b1, `GPIO_K_PULL, 4'h0};
                `GPIO_P2_LVL:   gpio_decode = {1'b1, `GPIO_K_LVL,  4'h1};
                `GPIO_P2_OUTV:  gpio_decode = {1'b1, `GPIO_K_OUTV, 4'h1};
                `GPIO_P2_DIR:   gpio_decode = {1'b1, `GPIO_K_DIR,  4'h1};
                `GPIO_P2_FLG:   gpio_decode = {1'b1, `GPIO_K_FLG,  4'h1};
                `GPIO_P2_POL:   gpio_decode = {1'b1, `GPIO_K_POL,  4'h1};
                `GPIO_P2_IEN:   gpio_decode = {1'b1, `GPIO_K_IEN,  4'h1};
                `GPIO_P2_FSEL:  gpio_decode = {1'b1, `GPIO_K_FSEL, 4'h1};
                `GPIO_P2_PULL:  gpio_decode = {1'b1, `GPIO_K_PULL, 4'h1};
                `GPIO_P3_LVL:   gpio_decode = {1'b1, `GPIO_K_LVL,  4'h2};
                `GPIO_P3_OUTV:  gpio_decode = {1'b1, `GPIO_K_OUTV, 4'h2};
                `GPIO_P3_DIR:   gpio_decode = {1'b1, `GPIO_K_DIR,  4'h2};
                `GPIO_P3_FSEL:  gpio_decode = {1'b1, `GPIO_K_FSEL, 4'h2};
                `GPIO_P3_PULL:  gpio_decode = {1'b1, `GPIO_K_PULL, 4'h2};
                `GPIO_P4_LVL:   gpio_decode = {1'b1, `GPIO_K_LVL,  4'h3};
                `GPIO_P4_OUTV:  gpio_decode = {1'b1, `GPIO_K_OUTV, 4'h3};
                `GPIO_P4_DIR:   gpio_decode = {1'b1, `GPIO_K_DIR,  4'h3};
                `GPIO_P4_FSEL:  gpio_decode = {1'b1, `GPIO_K_FSEL, 4'h3};
                `GPIO_P4_PULL:  gpio_decode = {1'b1, `GPIO_K_PULL, 4'h3};
                `GPIO_P5_LVL:   gpio_decode = {1'b1, `GPIO_K_LVL,  4'h4};
                `GPIO_P5_OUTV:  gpio_decode = {1'b1, `GPIO_K_OUTV, 4'h4};
                `GPIO_P5_DIR:   gpio_decode = {1'b1, `GPIO_K_DIR,  4'h4};
                `GPIO_P5_FSEL:  gpio_decode = {1'b1, `GPIO_K_FSEL, 4'h4};
                `GPIO_P5_PULL:  gpio_decode = {1'b1, `GPIO_K_PULL, 4'h4};
                `GPIO_P6_LVL:   gpio_decode = {1'b1, `GPIO_K_LVL,  4'h5};
                `GPIO_P6_OUTV:  gpio_decode = {1'b1, `GPIO_K_OUTV, 4'h5};
                `GPIO_P6_DIR:   gpio_decode = {1'b1, `GPIO_K_DIR,  4'h5};
                `GPIO_P6_FSEL:  gpio_decode = {1'b1, `GPIO_K_FSEL, 4'h5};
                `GPIO_P6_PULL:  gpio_decode = {1'b1, `GPIO_K_PULL, 4'h5};
                `GPIO_P7_LVL:   gpio_decode = {1'b1, `GPIO_K_LVL,  4'h6};
                `GPIO_P7_OUTV:  gpio_decode = {1'b1, `GPIO_K_OUTV, 4'h6};
                `GPIO_P7_DIR:   gpio_decode = {1'b1, `GPIO_K_DIR,  4'h6};
                `GPIO_P7_FSEL:  gpio_decode = {1'b1, `GPIO_K_FSEL, 4'h6};
                `GPIO_P7_PULL:  gpio_decode = {1'b1, `GPIO_K_PULL, 4'h6};
                `GPIO_P8_LVL:   gpio_decode = {1'b1, `GPIO_K_LVL,  4'h7};
                `GPIO_P8_OUTV:  gpio_decode = {1'b1, `GPIO_K_OUTV, 4'h7};
                `GPIO_P8_DIR:   gpio_decode = {1'b1, `GPIO_K_DIR,  4'h7};
                `GPIO_P8_FSEL:  gpio_decode = {1'b1, `GPIO_K_FSEL, 4'h7};
                `GPIO_P8_PULL:  gpio_decode = {1'b1, `GPIO_K_PULL, 4'h7};
                `GPIO_P9_LVL:   gpio_decode = {1'b1, `GPIO_K_LVL,  4'h8};
                `GPIO_P9_OUTV:  gpio_decode = {1'b1, `GPIO_K_OUTV, 4'h8};
                `GPIO_P9_DIR:   gpio_decode = {1'b1, `GPIO_K_DIR,  4'h8};
                `GPIO_P9_FSEL:  gpio_decode = {1'b1, `GPIO_K_FSEL, 4'h8};
                `GPIO_P9_PULL:  gpio_decode = {1'b1, `GPIO_K_PULL, 4'h8};
                `GPIO_P10_LVL:  gpio_decode = {1'b1, `GPIO_K_LVL,  4'h9};
                `GPIO_P10_OUTV: gpio_decode = {1'b1, `GPIO_K_OUTV, 4'h9};
                `GPIO_P10_DIR:  gpio_decode = {1'b1, `GPIO_K_DIR,  4'h9};
                `GPIO_P10_FSEL: gpio_decode = {1'b1, `GPIO_K_FSEL, 4'h9};
                `GPIO_P10_PULL: gpio_decode = {1'b1, `GPIO_K_PULL, 4'h9};
                default:        gpio_decode = 8'h00;
            endcase
        end
    endfunction

    function gpio_hit;
        input [7:0] d;
        input [2:0] kind;
        input [3:0] port;
        begin
            gpio_hit = d[7] & (d[6:4] == kind) & (d[3:0] == port);
        end
    endfunction

    // Upper lane written last, so it wins if both lanes hit
    function [7:0] gpio_upd;
        input [7:0] cur;
        input       h0;
        input [7:0] d0;
        input       h1;
        input [7:0] d1;
        begin
            gpio_upd = h1 ? d1 : (h0 ? d0 : cur);
        end
    endfunction

    reg  [7:0]  out_r   [0:9];
    reg  [7:0]  dir_r   [0:9];
    reg  [7:0]  sel_r   [0:9];
    reg  [7:0]  pull_r  [0:9];
    reg  [7:0]  pol_r   [0:1];
    reg  [7:0]  ien_r   [0:1];
    reg  [15:0] rdata_r;
    reg  [79:0] pad_out_r;
    reg  [79:0] pad_oe_n_r;
    reg  [79:0] pull_en_r;
    reg  [79:0] pull_up_r;
    reg  [79:0] periph_in_r;
    reg  [79:0] out_f;
    reg  [79:0] dir_f;
    reg  [79:0] sel_f;
    reg  [79:0] pull_f;
    reg  [7:0]  rd_byte [0:1];
    reg  [7:0]  dsel;
    reg  [1:0]  flag_we;
    reg  [7:0]  flag_wd [0:1];
    wire [7:0]  flags   [0:1];
    wire [7:0]  lane0_addr;
    wire [7:0]  lane1_addr;
    wire [7:0]  dec0;
    wire [7:0]  dec1;
    wire        we0;
    wire        we1;
    integer     p;
    integer     l;
    integer     f;
    integer     q;

    // Byte access uses low lane only; word access spans an even/odd pair
    assign lane0_addr = byte_i ? addr_i : {addr_i[7:1], 1'b0};
    assign lane1_addr = {addr_i[7:1], 1'b1};
    assign dec0       = gpio_decode(lane0_addr);
    assign dec1       = gpio_decode(lane1_addr);
    assign we0        = wr_i;
    assign we1        = wr_i & ~byte_i;

    always @(posedge clk_i) begin
        if (reset_i) begin
            for (p = 0; p < 10; p = p + 1) begin
                out_r[p]  <= `GPIO_RST_BYTE;
                dir_r[p]  <= `GPIO_RST_BYTE;
                sel_r[p]  <= (p == 1) ? `GPIO_RST_P2_FSEL : `GPIO_RST_BYTE;
                pull_r[p] <= `GPIO_RST_BYTE;
            end
            for (p = 0; p < 2; p = p + 1) begin
                pol_r[p] <= `GPIO_RST_BYTE;
                ien_r[p] <= `GPIO_RST_BYTE;
            end
        end else begin
            // Input level has no store; writes to it fall through
            for (p = 0; p < 10; p = p + 1) begin
                out_r[p]  <= gpio_upd(out_r[p],
                    we0 & gpio_hit(dec0, `GPIO_K_OUTV, p[3:0]), wdata_i[7:0],
                    we1 & gpio_hit(dec1, `GPIO_K_OUTV, p[3:0]), wdata_i[15:8]);
                dir_r[p]  <= gpio_upd(dir_r[p],
                    we0 & gpio_hit(dec0, `GPIO_K_DIR, p[3:0]), wdata_i[7:0],
                    we1 & gpio_hit(dec1, `GPIO_K_DIR, p[3:0]), wdata_i[15:8]);
                sel_r[p]  <= gpio_upd(sel_r[p],
                    we0 & gpio_hit(dec0, `GPIO_K_FSEL, p[3:0]), wdata_i[7:0],
                    we1 & gpio_hit(dec1, `GPIO_K_FSEL, p[3:0]), wdata_i[15:8]);
                pull_r[p] <= gpio_upd(pull_r[p],
                    we0 & gpio_hit(dec0, `GPIO_K_PULL, p[3:0]), wdata_i[7:0],
                    we1 & gpio_hit(dec1, `GPIO_K_PULL, p[3:0]), wdata_i[15:8]);
            end
            for (p = 0; p < 2; p = p + 1) begin
                pol_r[p] <= gpio_upd(pol_r[p],
                    we0 & gpio_hit(dec0, `GPIO_K_POL, p[3:0]), wdata_i[7:0],
                    we1 & gpio_hit(dec1, `GPIO_K_POL, p[3:0]), wdata_i[15:8]);
                ien_r[p] <= gpio_upd(ien_r[p],
                    we0 & gpio_hit(dec0, `GPIO_K_IEN, p[3:0]), wdata_i[7:0],
                    we1 & gpio_hit(dec1, `GPIO_K_IEN, p[3:0]), wdata_i[15:8]);
            end
        end
    end

    // Flag write strobes for the two edge ports
    // Own loop index per process, a shared one would ping-pong the blocks
    always @* begin
        for (f = 0; f < 2; f = f + 1) begin
            flag_we[f] = (we0 & gpio_hit(dec0, `GPIO_K_FLG, f[3:0]))
                       | (we1 & gpio_hit(dec1, `GPIO_K_FLG, f[3:0]));
            flag_wd[f] = (we1 & gpio_hit(dec1, `GPIO_K_FLG, f[3:0]))
                       ? wdata_i[15:8] : wdata_i[7:0];
        end
    end

    // Read mux per lane; unmapped addresses read zero
    always @* begin
        for (l = 0; l < 2; l = l + 1) begin
            dsel       = (l == 0) ? dec0 : dec1;
            rd_byte[l] = 8'h00;
            if (dsel[7]) begin
                case (dsel[6:4])
                    `GPIO_K_LVL:  rd_byte[l] =
                        pad_in_i[{dsel[3:0], 3'h0} +: 8];
                    `GPIO_K_OUTV: rd_byte[l] = out_r[dsel[3:0]];
                    `GPIO_K_DIR:  rd_byte[l] = dir_r[dsel[3:0]];
                    `GPIO_K_FLG:  rd_byte[l] = flags[dsel[0]];
                    `GPIO_K_POL:  rd_byte[l] = pol_r[dsel[0]];
                    `GPIO_K_IEN:  rd_byte[l] = ien_r[dsel[0]];
                    `GPIO_K_FSEL: rd_byte[l] = sel_r[dsel[3:0]];
                    `GPIO_K_PULL: rd_byte[l] = pull_r[dsel[3:0]];
                    default:      rd_byte[l] = 8'h00;
                endcase
            end
        end
    end

    // Flatten per-port bytes into pin vectors
    always @* begin
        for (q = 0; q < 10; q = q + 1) begin
            out_f[q*8 +: 8]  = out_r[q];
            dir_f[q*8 +: 8]  = dir_r[q];
            sel_f[q*8 +: 8]  = sel_r[q];
            pull_f[q*8 +: 8] = pull_r[q];
        end
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            rdata_r     <= 16'h0000;
            pad_out_r   <= 80'h0;
            pad_oe_n_r  <= {80{1'b1}};
            pull_en_r   <= 80'h0;
            pull_up_r   <= 80'h0;
            periph_in_r <= 80'h0;
        end else begin
            // Word read returns both ports of a pair in one access
            if (rd_i) begin
                rdata_r <= {(byte_i ? 8'h00 : rd_byte[1]), rd_byte[0]};
            end
            // Function select chooses the source, never the direction
            pad_out_r  <= (sel_f & periph_out_i)
                        | (~sel_f & out_f);
            pad_oe_n_r <= ~dir_f;
            pull_en_r  <= pull_f;
            pull_up_r  <= out_f;
            // Latch keeps the last pin value once the peripheral lets go
            periph_in_r <= (sel_f & pad_in_i)
                         | (~sel_f & periph_in_r);
        end
    end

    // Pin loopback means output or direction writes can also set flags
    gpio_edge u_edge_p1 (
        .clk_i               (clk_i),
        .reset_i             (reset_i),
        .pin_i               (pad_in_i[7:0]),
        .polarity_i          (pol_r[0]),
        .func_sel_i          (sel_r[0]),
        .irq_en_i            (ien_r[0]),
        .global_irq_enable_i (global_irq_enable_i),
        .flag_we_i           (flag_we[0]),
        .flag_wdata_i        (flag_wd[0]),
        .flags_o             (flags[0]),
        .irq_o               (port1_irq_o)
    );

    gpio_edge u_edge_p2 (
        .clk_i               (clk_i),
        .reset_i             (reset_i),
        .pin_i               (pad_in_i[15:8]),
        .polarity_i          (pol_r[1]),
        .func_sel_i          (sel_r[1]),
        .irq_en_i            (ien_r[1]),
        .global_irq_enable_i (global_irq_enable_i),
        .flag_we_i           (flag_we[1]),
        .flag_wdata_i        (flag_wd[1]),
        .flags_o             (flags[1]),
        .irq_o               (port2_irq_o)
    );

    assign rdata_o     = rdata_r;
    assign pad_out_o   = pad_out_r;
    assign pad_oe_n_o  = pad_oe_n_r;
    assign pull_en_o   = pull_en_r;
    assign pull_up_o   = pull_up_r;
    assign periph_in_o = periph_in_r;

endmodule // gpio_ports

/* File: verif/gpio_props.sv */
`timescale 1ns/100ps
module gpio_props (
    input wire        clk_i,
    input wire        reset_i,
    input wire [7:0]  addr_i,
    input wire [15:0] wdata_i,
    input wire        wr_i,
    input wire        rd_i,
    input wire        byte_i,
    input wire [15:0] rdata_o,
    input wire        global_irq_enable_i,
    input wire [79:0] pad_in_i,
    input wire [79:0] pad_oe_n_o,
    input wire [79:0] pull_up_o,
    input wire        port1_irq_o,
    input wire        port2_irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    irq_gie_gate_a: assert property (
        !global_irq_enable_i |-> !port1_irq_o && !port2_irq_o)
        else $error("port request without global enable");
    dir_drive_a: assert property (
        wr_i && byte_i && addr_i == 8'h22 |->
        ##2 pad_oe_n_o[7:0] == ~$past(wdata_i[7:0], 2))
        else $error("direction write did not reach pin enable");
    flag_sticky_a: assert property (
        $fell(port1_irq_o) |-> $past(wr_i) || !global_irq_enable_i)
        else $error("port 1 request dropped without a write");
    level_read_a: assert property (
        rd_i && byte_i && addr_i == 8'h20 |=>
        rdata_o[7:0] == $past(pad_in_i[7:0]))
        else $error("input register differs from pins");
    byte_upper_a: assert property (
        rd_i && byte_i |=> rdata_o[15:8] == 8'h00)
        else $error("byte read upper lane not zero");
    rdata_hold_a: assert property (!rd_i |=> $stable(rdata_o))
        else $error("read data moved without a read");
    // Pull outputs lag the register by one more edge
    pair_spare_a: assert property (
        wr_i && byte_i && addr_i == 8'h3a |->
        ##2 $stable(pull_up_o[63:56]))
        else $error("byte write disturbed partner port");
    pair_word_a: assert property (
        wr_i && !byte_i && addr_i == 8'h3a |->
        ##2 pull_up_o[63:48] == $past(wdata_i, 2))
        else $error("word write missed a port of the pair");
    reset_idle_a: assert property (
        disable iff (1'b0) reset_i |=> &pad_oe_n_o && !port2_irq_o)
        else $error("pins driven after reset");
endmodule // gpio_props

/* File: verif/gpio_pins.sv */
`timescale 1ns/100ps
module gpio_pins (
    input  wire        clk_i,
    input  wire [79:0] out_i,
    input  wire [79:0] oe_n_i,
    input  wire [79:0] pull_en_i,
    input  wire [79:0] pull_up_i,
    input  wire [79:0] ext_en_i,
    input  wire [79:0] ext_val_i,
    output reg  [79:0] pad_o
);
    reg     float_r = 1'b0;
    integer i;
    // Floating pins wobble so no settled value can pass by luck
    always @(posedge clk_i) float_r <= ~float_r;
    always @* begin
        for (i = 0; i < 80; i = i + 1) begin
            if (!oe_n_i[i]) pad_o[i] = out_i[i];
            else if (ext_en_i[i]) pad_o[i] = ext_val_i[i];
            else if (pull_en_i[i]) pad_o[i] = pull_up_i[i];
            else pad_o[i] = float_r ^ i[0];
        end
    end
endmodule // gpio_pins

/* File: verif/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    reg         clk_i = 1'b0;
    reg         reset_i = 1'b1;
    reg  [7:0]  addr = 8'h00;
    reg  [15:0] wdata = 16'h0000;
    reg         wr = 1'b0, rd = 1'b0, byt = 1'b1, global_irq_enable = 1'b0;
    reg  [79:0] p_out = {10{8'h5a}};
    reg  [79:0] ext_en = ~(80'hff << 24), ext_val = 80'h0;
    wire [15:0] rdata;
    wire [79:0] pad_in, pad_out, oe_n, pull_en, pull_up, p_in;
    wire        irq1, irq2;
    integer     failures = 0, checked = 0, cycles = 0, k;
    reg  [7:0]  rw_a [0:6];
    always #2 clk_i = ~clk_i;
    gpio_ports dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .byte_i(byt),
        .rdata_o(rdata), .global_irq_enable_i(global_irq_enable), .pad_in_i(pad_in),
        .pad_out_o(pad_out), .pad_oe_n_o(oe_n), .pull_en_o(pull_en),
        .pull_up_o(pull_up), .periph_out_i(p_out), .periph_in_o(p_in),
        .port1_irq_o(irq1), .port2_irq_o(irq2));
    gpio_pins u_pins (.clk_i(clk_i), .out_i(pad_out), .oe_n_i(oe_n),
        .pull_en_i(pull_en), .pull_up_i(pull_up), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .pad_o(pad_in));
    task chk(input [79:0] g, input [79:0] e);
        begin
            checked = checked + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("mismatch at %0t: got %h want %h", $time, g, e);
            end
        end
    endtask
    task wr_reg(input [7:0] a, input [15:0] d, input b);
        begin
            addr = a; wdata = d; byt = b; wr = 1'b1;
            @(posedge clk_i); #1;
            wr = 1'b0;
            @(posedge clk_i);
            #1;
        end
    endtask
    task rd_reg(input [7:0] a, input b, input [15:0] e);
        begin
            addr = a; byt = b; rd = 1'b1;
            @(posedge clk_i); #1;
            rd = 1'b0;
            chk(rdata, e);
            @(posedge clk_i);
            #1;
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk_i);
            #1;
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", checked, failures);
            if (failures == 0 && checked > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    // Long stall means a lost handshake; end the run rather than hang
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            tally_and_finish;
        end
    end
    initial begin
        rw_a[0] = 8'h21; rw_a[1] = 8'h22; rw_a[2] = 8'h24; rw_a[3] = 8'h25;
        rw_a[4] = 8'h27; rw_a[5] = 8'h36; rw_a[6] = 8'h17;
        cyc(8);
        reset_i = 1'b0;
        rd_reg(8'h2e, 1, 16'h00c0);
        rd_reg(8'h22, 1, 16'h0000);
        chk(oe_n, {80{1'b1}});
        $display("test reset done");
        for (k = 0; k < 7; k = k + 1) begin
            wr_reg(rw_a[k], {8'h00, rw_a[k] ^ 8'h5a}, 1);
            rd_reg(rw_a[k], 1, {8'h00, rw_a[k] ^ 8'h5a});
            wr_reg(rw_a[k], 16'h0000, 1);
        end
        wr_reg(8'h20, 16'h00ff, 1);
        cyc(2);
        rd_reg(8'h20, 1, 16'h0000);
        wr_reg(8'h00, 16'hffff, 0);
        rd_reg(8'h00, 0, 16'h0000);
        $display("test registers done");
        wr_reg(8'h3a, 16'h5555, 0);
        rd_reg(8'h3a, 0, 16'h5555);
        wr_reg(8'h3a, 16'h0001, 1);
        rd_reg(8'h3b, 1, 16'h0055);
        rd_reg(8'h3a, 0, 16'h5501);
        wr_reg(8'h0e, 16'hffff, 0);
        wr_reg(8'h0e, 16'h0000, 1);
        rd_reg(8'h0e, 0, 16'hff00);
        $display("test pairs done");
        wr_reg(8'h1a, 16'h00ff, 1);
        wr_reg(8'h19, 16'h00a5, 1);
        cyc(2);
        chk(pad_out[23:16], 8'ha5);
        chk(oe_n[23:16], 8'h00);
        rd_reg(8'h18, 1, 16'h00a5);
        wr_reg(8'h11, 16'h00ff, 1);
        wr_reg(8'h1d, 16'h000f, 1);
        cyc(2);
        rd_reg(8'h1c, 1, 16'h000f);
        $display("test pins done");
        ext_val[39:32] = 8'h3c;
        wr_reg(8'h33, 16'h00ff, 1);
        rd_reg(8'h32, 1, 16'h0000);
        cyc(4);
        chk(pad_out[39:32], 8'h5a);
        chk(p_in[39:32], 8'h3c);
        wr_reg(8'h33, 16'h0000, 1);
        cyc(4);
        ext_val[39:32] = 8'hc3;
        cyc(4);
        chk(p_in[39:32], 8'h3c);
        $display("test function done");
        global_irq_enable = 1'b1;
        wr_reg(8'h23, 16'h0000, 1);
        wr_reg(8'h25, 16'h001f, 1);
        wr_reg(8'h24, 16'h0002, 1);
        cyc(4);
        rd_reg(8'h23, 1, 16'h0002);
        ext_val[2] = 1'b1;
        cyc(4);
        // Rising pin 2 flagged itself; clear it so a wrong set would show
        wr_reg(8'h23, 16'h0002, 1);
        wr_reg(8'h24, 16'h0006, 1);
        cyc(4);
        rd_reg(8'h23, 1, 16'h0002);
        wr_reg(8'h23, 16'h0000, 1);
        chk(irq1, 1'b0);
        ext_val[0] = 1'b1;
        cyc(4);
        chk({irq2, irq1}, 2'h1);
        rd_reg(8'h23, 1, 16'h0001);
        cyc(10);
        wr_reg(8'h23, 16'h0000, 1);
        cyc(4);
        chk(irq1, 1'b0);
        ext_val[2] = 1'b0;
        cyc(4);
        rd_reg(8'h23, 1, 16'h0004);
        wr_reg(8'h23, 16'h0000, 1);
        wr_reg(8'h26, 16'h0008, 1);
        ext_val[3] = 1'b1;
        cyc(4);
        rd_reg(8'h23, 1, 16'h0000);
        wr_reg(8'h22, 16'h0010, 1);
        wr_reg(8'h21, 16'h0010, 1);
        cyc(4);
        rd_reg(8'h23, 1, 16'h0010);
        global_irq_enable = 1'b0;
        cyc(1);
        chk(irq1, 1'b0);
        global_irq_enable = 1'b1;
        cyc(1);
        chk(irq1, 1'b1);
        wr_reg(8'h2d, 16'h0001, 1);
        wr_reg(8'h2b, 16'h0001, 1);
        chk(irq2, 1'b1);
        rd_reg(8'h2b, 1, 16'h0001);
        $display("test interrupts done");
        tally_and_finish;
    end
endmodule // tb_top
bind gpio_ports gpio_props u_props (.clk_i(clk_i), .reset_i(reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .byte_i(byte_i), .rdata_o(rdata_o),
    .global_irq_enable_i(global_irq_enable_i), .pad_in_i(pad_in_i),
    .pad_oe_n_o(pad_oe_n_o), .pull_up_o(pull_up_o),
    .port1_irq_o(port1_irq_o), .port2_irq_o(port2_irq_o));
